// ---- hw/rts_pkg.sv ----
// Package with constants and types of the resistive touch sequencer.
// Behaviour
// - Window pins +0..+3 are top X, bottom X, right Y and left Y.
// - Pin offset zero places the window on analog pins 0 to 3.
// - Pin offset one places the window on pins 1 to 4, freeing pin 0.
// - Drive select low: pins measure and ground, supply pins drive supply.
// - Drive select resets to zero, so supply pins drive by default.
// - Drive select high: window pins +0 and +2 drive supply directly.
// - Drive select high releases both supply pins for general use.
// - Vertical axis: supply and ground on X pins, Y pins tristated.
// - Each axis also converts both driven electrodes for offset correction.
// - Horizontal axis: X pins tristated, supply and ground on Y pins.
// - Contact detection starts when software sets the enable bit.
// - Detection grounds both X pins, pulls up Y right, floats Y left.
// - Debounce length runs from one to two to the fifteen clocks.
// - Present flag is set while contact current flows.
// - Absent flag is set while no contact current flows.
// - Flags change only after the new state held for the debounce time, except that clearing the enable bit clears both.
// - Each flag raises the interrupt request when its mask bit is one.
// - A debounced contact can trigger a conversion sequence.
// - Plain mode converts every enabled channel and nothing else.
// - Touch mode converts the touch group between other enabled channels.
// - Touch mode select chooses between plain and touch mode.
// - Touch mode enables window channels; sequencer takes over at offset +0.
package rts_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RTS_CTRL_OFS      = 8'h00;
  localparam logic [7:0] RTS_MODE_OFS      = 8'h04;
  localparam logic [7:0] RTS_TRIG_OFS      = 8'h0C;
  localparam logic [7:0] RTS_STATUS_OFS    = 8'h14;
  localparam logic [7:0] RTS_IRQ_EN_OFS    = 8'h20;
  localparam logic [7:0] RTS_IRQ_DIS_OFS   = 8'h24;
  localparam logic [7:0] RTS_IRQ_MASK_OFS  = 8'h28;
  localparam logic [7:0] RTS_CHAN_EN_OFS   = 8'h40;
  localparam logic [7:0] RTS_CHAN_DIS_OFS  = 8'h44;
  localparam logic [7:0] RTS_CHAN_STAT_OFS = 8'h48;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RTS_CTRL_START_BIT  = 1;
  localparam int RTS_MODE_TOUCH_BIT  = 0;
  localparam int RTS_MODE_DETECT_BIT = 1;
  localparam int RTS_MODE_DRIVE_BIT  = 2;
  localparam int RTS_MODE_OFFSET_LSB = 16;
  localparam int RTS_MODE_DBC_LSB    = 28;
  localparam int RTS_TRIG_CONTACT_BIT = 0;
  localparam int RTS_ST_READY_BIT    = 0;
  localparam int RTS_ST_PRESENT_BIT  = 1;
  localparam int RTS_ST_ABSENT_BIT   = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] RTS_MODE_RESET = 32'h0000_0000;
  localparam logic [7:0]  RTS_CHAN_RESET = 8'h00;
  localparam logic [2:0]  RTS_TOUCH_STEPS = 3'h6;
  localparam logic [2:0]  RTS_AXIS_STEPS  = 3'h3;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along idle, scan, convert
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RTS_IDLE = 2'h0,
    RTS_SCAN = 2'h1,
    RTS_CONV = 2'h3
  } rts_state_t;

endpackage

// ---- hw/rts_seq.sv ----
// Resistive touch sequencer with contact debouncer and Wishbone registers.
`timescale 1ns/1ps
module rts_seq
  import rts_pkg::*;
#(
  parameter int NPIN = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic [7:0]       adr_i,
  input  wire logic [31:0]      dat_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic             we_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // Analog pins
  input  wire logic [NPIN-1:0]  ad_in_i,
  output logic      [NPIN-1:0]  ad_out_o,
  output logic      [NPIN-1:0]  ad_oe_o,
  output logic      [NPIN-1:0]  ad_pu_o,
  // Dedicated supply pins
  output logic                  x_supply_out_o,
  output logic                  x_supply_oe_o,
  output logic                  y_supply_out_o,
  output logic                  y_supply_oe_o,
  // Converter cell
  output logic                  conv_start_o,
  output logic      [2:0]       conv_chan_o,
  input  wire logic             conv_done_i,
  // Events
  output logic                  irq_o,
  output logic                  busy_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rts_state_t       state;
    logic [2:0]       chan;
    logic [2:0]       tstep;
    logic             in_touch;
    logic [31:0]      mode;
    logic             trig_contact;
    logic [7:0]       chen;
    logic [1:0]       imask;
    logic             ack;
    logic [31:0]      rdat;
    logic [NPIN-1:0]  sync1;
    logic [NPIN-1:0]  sync2;
    logic [15:0]      dbc_cnt;
    logic             present;
    logic             absent;
    logic [NPIN-1:0]  ad_out;
    logic [NPIN-1:0]  ad_oe;
    logic [NPIN-1:0]  ad_pu;
    logic             xs_out;
    logic             xs_oe;
    logic             ys_out;
    logic             ys_oe;
    logic             conv_start;
    logic [2:0]       conv_chan;
    logic             irq;
    logic             busy;
  } rts_reg_t;

  rts_reg_t q;
  rts_reg_t d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pin index inside the touch window.
  function automatic logic [2:0] win_pin(input logic [2:0] ofs, input logic [1:0] k);
    win_pin = 3'(ofs + {1'b0, k});
  endfunction

  // Window member selected by each touch step.
  function automatic logic [1:0] step_member(input logic [2:0] step);
    case (step)
      3'h0:    step_member = 2'h1;
      3'h1:    step_member = 2'h0;
      3'h2:    step_member = 2'h2;
      3'h3:    step_member = 2'h3;
      3'h4:    step_member = 2'h2;
      default: step_member = 2'h0;
    endcase
  endfunction

  logic [2:0]  tspo;
  logic        touch_mode;
  logic        detect_en;
  logic        drive_sel;
  logic [3:0]  dbc_len;
  logic [15:0] dbc_last;
  logic [31:0] wmask;
  logic        wb_req;
  logic        wb_wr;
  logic [7:0]  chen_eff;
  logic        raw_contact;
  logic        start_req;

  assign tspo       = q.mode[RTS_MODE_OFFSET_LSB +: 3];
  assign touch_mode = q.mode[RTS_MODE_TOUCH_BIT];
  assign detect_en  = q.mode[RTS_MODE_DETECT_BIT];
  assign drive_sel  = q.mode[RTS_MODE_DRIVE_BIT];
  assign dbc_len    = q.mode[RTS_MODE_DBC_LSB +: 4];
  assign dbc_last   = 16'((17'h1 << dbc_len) - 17'h1);
  assign wmask      = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wb_req     = cyc_i & stb_i & ~q.ack;
  assign wb_wr      = wb_req & we_i;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack        = wb_req;
    d.conv_start = 1'b0;
    d.sync1      = ad_in_i;
    d.sync2      = q.sync1;

    // Touch mode adds the window channels to the enabled set.
    chen_eff = q.chen;
    if (touch_mode) begin
      for (int k = 0; k < 4; k++) begin
        chen_eff[win_pin(tspo, 2'(k))] = 1'b1;
      end
    end

    // Contact current pulls the right Y pin low against its pull-up.
    raw_contact = ~q.sync2[win_pin(tspo, 2'h2)];

    // Register writes and reads.
    start_req = 1'b0;
    if (wb_wr) begin
      case (adr_i)
        RTS_CTRL_OFS:     start_req = dat_i[RTS_CTRL_START_BIT] & sel_i[0];
        RTS_MODE_OFS:     d.mode = (q.mode & ~wmask) | (dat_i & wmask);
        RTS_TRIG_OFS:     if (sel_i[0]) d.trig_contact = dat_i[RTS_TRIG_CONTACT_BIT];
        RTS_IRQ_EN_OFS:   if (sel_i[0]) d.imask = q.imask | dat_i[1:0];
        RTS_IRQ_DIS_OFS:  if (sel_i[0]) d.imask = q.imask & ~dat_i[1:0];
        RTS_CHAN_EN_OFS:  if (sel_i[0]) d.chen = q.chen | dat_i[7:0];
        RTS_CHAN_DIS_OFS: if (sel_i[0]) d.chen = q.chen & ~dat_i[7:0];
        default: ;
      endcase
    end
    d.rdat = 32'h0000_0000;
    if (wb_req && !we_i) begin
      case (adr_i)
        RTS_MODE_OFS:      d.rdat = q.mode;
        RTS_TRIG_OFS:      d.rdat = {31'h0000_0000, q.trig_contact};
        RTS_STATUS_OFS:    d.rdat = {29'h0000_0000, q.absent, q.present, ~q.busy};
        RTS_IRQ_MASK_OFS:  d.rdat = {30'h0000_0000, q.imask};
        RTS_CHAN_STAT_OFS: d.rdat = {24'h00_0000, chen_eff};
        default:           d.rdat = 32'h0000_0000;
      endcase
    end

    // Debouncer: frozen while a sequence owns the pins.
    if (!detect_en) begin
      d.dbc_cnt = 16'h0000;
      d.present = 1'b0;
      d.absent  = 1'b0;
    end else if (q.state == RTS_IDLE) begin
      if (raw_contact == q.present && (q.present || q.absent)) begin
        d.dbc_cnt = 16'h0000;
      end else if (q.dbc_cnt >= dbc_last) begin
        d.dbc_cnt = 16'h0000;
        d.present = raw_contact;
        d.absent  = ~raw_contact;
      end else begin
        d.dbc_cnt = 16'(q.dbc_cnt + 16'h0001);
      end
    end

    // A fresh debounced contact starts a sequence when so configured.
    if (q.trig_contact && d.present && !q.present) begin
      start_req = 1'b1;
    end

    // Conversion sequencer.
    case (q.state)
      RTS_IDLE: begin
        if (start_req) begin
          d.state    = RTS_SCAN;
          d.chan     = 3'h0;
          d.tstep    = 3'h0;
          d.in_touch = 1'b0;
        end
      end
      RTS_SCAN: begin
        if (q.in_touch) begin
          d.conv_start = 1'b1;
          d.conv_chan  = win_pin(tspo, step_member(q.tstep));
          d.state      = RTS_CONV;
        end else if (touch_mode && q.chan == tspo) begin
          d.in_touch = 1'b1;
          d.tstep    = 3'h0;
        end else if (chen_eff[q.chan]) begin
          d.conv_start = 1'b1;
          d.conv_chan  = q.chan;
          d.state      = RTS_CONV;
        end else if (q.chan == 3'(NPIN - 1)) begin
          d.state = RTS_IDLE;
        end else begin
          d.chan = 3'(q.chan + 3'h1);
        end
      end
      RTS_CONV: begin
        if (conv_done_i) begin
          d.state = RTS_SCAN;
          if (q.in_touch && q.tstep != RTS_TOUCH_STEPS - 3'h1) begin
            d.tstep = 3'(q.tstep + 3'h1);
          end else if (q.in_touch && q.chan >= 3'(NPIN - 4)) begin
            d.in_touch = 1'b0;
            d.state    = RTS_IDLE;
          end else if (q.in_touch) begin
            d.in_touch = 1'b0;
            d.chan     = 3'(q.chan + 3'h4);
          end else if (q.chan == 3'(NPIN - 1)) begin
            d.state = RTS_IDLE;
          end else begin
            d.chan = 3'(q.chan + 3'h1);
          end
        end
      end
      default: d.state = RTS_IDLE;
    endcase
    d.busy = (d.state != RTS_IDLE);

    // Pin patterns.
    d.ad_out = '0;
    d.ad_oe  = '0;
    d.ad_pu  = '0;
    d.xs_out = 1'b0;
    d.xs_oe  = 1'b0;
    d.ys_out = 1'b0;
    d.ys_oe  = 1'b0;
    if (d.in_touch) begin
      if (d.tstep < RTS_AXIS_STEPS) begin
        d.ad_oe[win_pin(tspo, 2'h1)] = 1'b1;
        if (drive_sel) begin
          d.ad_oe[win_pin(tspo, 2'h0)]  = 1'b1;
          d.ad_out[win_pin(tspo, 2'h0)] = 1'b1;
        end else begin
          d.xs_oe  = 1'b1;
          d.xs_out = 1'b1;
        end
      end else begin
        d.ad_oe[win_pin(tspo, 2'h3)] = 1'b1;
        if (drive_sel) begin
          d.ad_oe[win_pin(tspo, 2'h2)]  = 1'b1;
          d.ad_out[win_pin(tspo, 2'h2)] = 1'b1;
        end else begin
          d.ys_oe  = 1'b1;
          d.ys_out = 1'b1;
        end
      end
    end else if (detect_en) begin
      // Restored as soon as the sequence leaves the touch group.
      d.ad_oe[win_pin(tspo, 2'h0)] = 1'b1;
      d.ad_oe[win_pin(tspo, 2'h1)] = 1'b1;
      d.ad_pu[win_pin(tspo, 2'h2)] = 1'b1;
    end
    if (drive_sel) begin
      d.xs_oe = 1'b0;
      d.ys_oe = 1'b0;
    end

    d.irq = (d.present & q.imask[0]) | (d.absent & q.imask[1]);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q              <= '0;
      q.state        <= RTS_IDLE;
      q.mode         <= RTS_MODE_RESET;
      q.chen         <= RTS_CHAN_RESET;
    end else begin
      q <= d;
    end
  end

  assign dat_o          = q.rdat;
  assign ack_o          = q.ack;
  assign ad_out_o       = q.ad_out;
  assign ad_oe_o        = q.ad_oe;
  assign ad_pu_o        = q.ad_pu;
  assign x_supply_out_o = q.xs_out;
  assign x_supply_oe_o  = q.xs_oe;
  assign y_supply_out_o = q.ys_out;
  assign y_supply_oe_o  = q.ys_oe;
  assign conv_start_o   = q.conv_start;
  assign conv_chan_o    = q.conv_chan;
  assign irq_o          = q.irq;
  assign busy_o         = q.busy;

endmodule

// ---- tb/rts_seq_checker.sv ----
// Concurrent port checks for the touch sequencer.
`timescale 1ns/1ps
module rts_seq_checker #(
  parameter int NPIN = 8
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            cyc_i,
  input wire logic            stb_i,
  input wire logic [31:0]     dat_o,
  input wire logic            ack_o,
  input wire logic [NPIN-1:0] ad_oe_o,
  input wire logic [NPIN-1:0] ad_pu_o,
  input wire logic            x_supply_out_o,
  input wire logic            x_supply_oe_o,
  input wire logic            y_supply_out_o,
  input wire logic            y_supply_oe_o,
  input wire logic            conv_start_o,
  input wire logic            conv_done_i,
  input wire logic            busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or long");
  property p_dat; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data outside answer");
  property p_xsup; x_supply_oe_o |-> x_supply_out_o && busy_o; endproperty
  a_xsup: assert property (p_xsup) else $error("x supply pin misdriven");
  property p_ysup; y_supply_oe_o |-> y_supply_out_o && busy_o; endproperty
  a_ysup: assert property (p_ysup) else $error("y supply pin misdriven");
  property p_axes; !(x_supply_oe_o && y_supply_oe_o); endproperty
  a_axes: assert property (p_axes) else $error("both axes supplied");
  property p_pu; $onehot0(ad_pu_o) && (ad_pu_o & ad_oe_o) == '0; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on driven pin");
  property p_start; conv_start_o |-> busy_o ##1 !conv_start_o; endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");
  property p_done; conv_done_i && busy_o |=> !conv_start_o; endproperty
  a_done: assert property (p_done) else $error("next start too soon");
endmodule
bind rts_seq rts_seq_checker #(.NPIN(NPIN)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .ad_oe_o(ad_oe_o), .ad_pu_o(ad_pu_o),
  .x_supply_out_o(x_supply_out_o), .x_supply_oe_o(x_supply_oe_o),
  .y_supply_out_o(y_supply_out_o), .y_supply_oe_o(y_supply_oe_o),
  .conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .busy_o(busy_o));

// ---- tb/rts_film_model.sv ----
// Touch films and converter cell as seen from the sequencer pins.
`timescale 1ns/1ps
module rts_film_model #(
  parameter int NPIN = 8
) (
  input wire logic            clk_i,
  input wire logic            touch_i,
  input wire logic [NPIN-1:0] ad_out_i,
  input wire logic [NPIN-1:0] ad_oe_i,
  input wire logic [NPIN-1:0] ad_pu_i,
  input wire logic            conv_start_i,
  output logic     [NPIN-1:0] ad_in_o,
  output logic                conv_done_o
);
  logic [NPIN-1:0] flt_q = NPIN'(32'h55);
  int              wait_n = 0;
  logic            gnd;
  initial conv_done_o = 1'b0;
  assign gnd = |(ad_oe_i & ~ad_out_i);
  // Undriven film without pull-up shows a pattern that flips every cycle, never a held value.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (ad_oe_i[i]) ad_in_o[i] = ad_out_i[i];
      else if (ad_pu_i[i]) ad_in_o[i] = !(touch_i && gnd);
      else ad_in_o[i] = flt_q[i];
    end
  end
  always @(posedge clk_i) begin
    flt_q <= ~flt_q;
    conv_done_o <= (wait_n == 1);
    if (conv_start_i) wait_n <= 2 + $urandom % 6;
    else if (wait_n > 0) wait_n <= wait_n - 1;
  end
endmodule

// ---- tb/rts_seq_test.sv ----
// Self-checking bench for the resistive touch sequencer.
`timescale 1ns/1ps
module rts_seq_test;
  import rts_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  sel_i = 4'h0;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        touch = 1'b0;
  logic [31:0] dat_o, rd;
  logic [7:0]  ad_in_i, ad_out_o, ad_oe_o, ad_pu_o, en;
  logic        ack_o, xo, xe, yo, ye, conv_start_o, conv_done_i, irq_o, busy_o;
  logic [2:0]  conv_chan_o;
  logic [3:0]  w, wo;
  int          err_count = 0, check_count = 0, q[$], qe, cur_t, cur_drv;
  always #4 clk_i = ~clk_i;
  rts_seq DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .ad_in_i(ad_in_i), .ad_out_o(ad_out_o), .ad_oe_o(ad_oe_o), .ad_pu_o(ad_pu_o),
    .x_supply_out_o(xo), .x_supply_oe_o(xe), .y_supply_out_o(yo), .y_supply_oe_o(ye),
    .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i),
    .irq_o(irq_o), .busy_o(busy_o));
  rts_film_model u_film (.clk_i(clk_i), .touch_i(touch), .ad_out_i(ad_out_o),
    .ad_oe_i(ad_oe_o), .ad_pu_i(ad_pu_o), .conv_start_i(conv_start_o),
    .ad_in_o(ad_in_i), .conv_done_o(conv_done_i));
  task check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wb(input logic w_, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w_; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin err_count++; give_verdict(); end
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task set_mode(input logic tm, det, drv, input logic [2:0] t, input logic [3:0] dbc);
    wb(1'b1, RTS_MODE_OFS, {dbc, 9'h0, t, 13'h0, drv, det, tm});
    cur_t = t;
    cur_drv = drv;
  endtask
  // Expected order: class times 8 plus channel; class 1 is X axis, 2 is Y axis.
  function void plan(input logic [7:0] e, input bit tm, input int t);
    q = {};
    for (int c = 0; c < 8; c++) begin
      if (tm && c == t) q = {q, 9 + t, 8 + t, 10 + t, 19 + t, 18 + t, 16 + t};
      else if (e[c] && !(tm && c > t && c <= t + 3)) q.push_back(c);
    end
  endfunction
  task run(input bit sw, input string nm);
    int n;
    if (sw) wb(1'b1, RTS_CTRL_OFS, 32'h2);
    n = 0;
    while (busy_o !== 1'b1 && n < 50) begin @(posedge clk_i); n++; end
    while (busy_o === 1'b1 && n < 3000) begin @(posedge clk_i); n++; end
    if (busy_o === 1'b1) begin err_count++; give_verdict(); end
    check(q.size(), 0, "conversions left");
    $display("test %s done", nm);
  endtask
  task pins_idle();
    repeat (2) @(posedge clk_i);
    check({ad_oe_o[3:0], ad_oe_o[3:0] & ad_out_o[3:0], ad_pu_o[3:0]}, 12'h304, "detect");
  endtask
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) begin
      qe = (q.size() > 0) ? q.pop_front() : 99;
      check(conv_chan_o, (qe == 99) ? 32'hFF : 32'(qe % 8), "channel");
      w = 4'(ad_oe_o >> cur_t);
      wo = 4'((ad_oe_o & ad_out_o) >> cur_t);
      if (qe >= 16 && qe < 99)
        check({w, wo, xe, xo, ye, yo}, cur_drv ? 12'hC40 : 12'h803, "y axis");
      else if (qe >= 8 && qe < 99)
        check({w, wo, xe, xo, ye, yo}, cur_drv ? 12'h310 : 12'h20C, "x axis");
    end
  end
  initial begin
    void'($urandom(7958));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, RTS_MODE_OFS, 32'h0);
    check(rd, RTS_MODE_RESET, "mode reset");
    check({xe, ye}, 2'h0, "supply idle");
    wb(1'b0, 8'h3C, 32'h0);
    check(rd, 32'h0, "unmapped");
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      en = $urandom;
      if (k > 1) set_mode(1'b1, 1'b0, k[0], 3'(k - 2), 4'h0);
      wb(1'b1, RTS_CHAN_DIS_OFS, 32'hFF);
      wb(1'b1, RTS_CHAN_EN_OFS, {24'h0, en});
      wb(1'b0, RTS_CHAN_STAT_OFS, 32'h0);
      check(rd, {24'h0, en | (k > 1 ? 8'hF << (k - 2) : 8'h0)}, "chan stat");
      plan(en, k > 1, k - 2);
      run(1'b1, "sequence");
    end
    set_mode(1'b0, 1'b1, 1'b0, 3'h0, 4'h2);
    repeat (20) @(posedge clk_i);
    wb(1'b0, RTS_STATUS_OFS, 32'h0);
    check(rd[2:1], 2'h2, "absent");
    pins_idle();
    touch <= 1'b1;
    repeat (2) @(posedge clk_i);
    touch <= 1'b0;
    repeat (20) @(posedge clk_i);
    wb(1'b0, RTS_STATUS_OFS, 32'h0);
    check(rd[2:1], 2'h2, "glitch");
    touch <= 1'b1;
    repeat (20) @(posedge clk_i);
    wb(1'b0, RTS_STATUS_OFS, 32'h0);
    check(rd[2:1], 2'h1, "present");
    wb(1'b1, RTS_IRQ_EN_OFS, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1, "irq present");
    wb(1'b1, RTS_IRQ_DIS_OFS, 32'h1);
    wb(1'b1, RTS_IRQ_EN_OFS, 32'h2);
    wb(1'b0, RTS_IRQ_MASK_OFS, 32'h0);
    check(rd, 32'h2, "mask");
    check(irq_o, 1'b0, "irq masked");
    touch <= 1'b0;
    repeat (20) @(posedge clk_i);
    check(irq_o, 1'b1, "irq absent");
    wb(1'b1, RTS_IRQ_DIS_OFS, 32'h2);
    $display("test detect done");
    set_mode(1'b1, 1'b1, 1'b0, 3'h0, 4'h2);
    wb(1'b1, RTS_TRIG_OFS, 32'h1);
    wb(1'b1, RTS_CHAN_DIS_OFS, 32'hFF);
    repeat (20) @(posedge clk_i);
    plan(8'h0, 1'b1, 0);
    touch <= 1'b1;
    run(1'b0, "contact trigger");
    pins_idle();
    give_verdict();
  end
endmodule
